/* design/acq_sequencer.sv */
`timescale 1ns/1ps
module acq_sequencer #(
  parameter int DATA_W     = acq_pkg::ACQ_DATA_W,
  parameter int FIFO_DEPTH = acq_pkg::ACQ_FIFO_DEPTH,
  parameter int NCH        = acq_pkg::ACQ_MAX_CH,
  parameter bit HAS_ANALOG = 1'b1
) (
  input  wire logic                    mclk,           // System clock.
  input  wire logic                    rstn,           // Sync reset, low.
  input  wire acq_pkg::acq_cfg_type    cfg,            // Configuration.
  input  wire acq_pkg::acq_range_type  range_tab [NCH],// Range per channel.
  input  wire logic                    arm,            // Start paced run.
  input  wire logic                    stop,           // Stop the run.
  input  wire logic                    sw_convert,     // One conversion.
  input  wire logic                    clr_overflow,   // Clear overflow.
  input  wire logic                    pacing_pin,     // External pacing.
  input  wire logic                    start_pin,      // Digital start.
  input  wire logic                    ref_pin,        // Digital reference.
  input  wire logic                    pause_pin,      // Digital pause.
  input  wire logic                    analog_cmp_pin, // Analog comparator.
  output logic                         conv_start_q,   // Converter start.
  input  wire logic                    conv_valid,     // Converter result.
  input  wire logic [DATA_W-1:0]       conv_data,      // Converter word.
  output logic [acq_pkg::ACQ_CH_W-1:0] chan_sel_q,     // Mux channel.
  output acq_pkg::acq_range_type       pga_range_q,    // Amplifier range.
  output logic [DATA_W-1:0]            data_q,         // Sample to host.
  output logic                         data_valid_q,   // Sample present.
  input  wire logic                    host_ready,     // Host takes sample.
  output acq_pkg::acq_status_type      status_q        // Status flags.
);
  import acq_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH + 1);

  // Channel numbers must fit their field and the data must be at least one bit wide.
  if ((NCH < 1) || (NCH > (1 << ACQ_CH_W)) || (DATA_W < 1)) begin : g_bad
    $error("acq_sequencer: NCH or DATA_W out of range");
  end

  typedef struct packed {
    acq_state_type         st;
    logic [ACQ_NPIN-1:0]   sync1;
    logic [ACQ_NPIN-1:0]   sync2;
    logic [ACQ_NPIN-1:0]   sync3;
    logic [ACQ_NPIN-1:0]   lvl;
    logic [ACQ_DIV_W-1:0]  div_cnt;
    logic [ACQ_CH_W-1:0]   chan;
    logic [ACQ_CNT_W-1:0]  samples;
    logic                  tick_pend;
    logic                  conv_start;
    logic [ACQ_CH_W-1:0]   chan_sel;
    acq_range_type         range;
    logic [DATA_W-1:0]     data;
    logic                  data_valid;
    acq_status_type        status;
  } acq_seq_st_type;

  acq_seq_st_type      r_q;
  acq_seq_st_type      r_d;
  logic [ACQ_NPIN-1:0] pins;
  logic [ACQ_NPIN-1:0] rise;
  logic                start_rise;
  logic                ref_rise;
  logic                pause_lvl;
  logic                pace_tick;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [DATA_W-1:0]   fifo_out_data;
  logic [LW-1:0]       fifo_level;
  logic                last_sample;
  logic                counting;

  assign pins = {analog_cmp_pin, pause_pin, ref_pin, start_pin, pacing_pin};

  //////////////////////////////////////////////////////////////////////////////
  // Sample store between converter and host.
  //////////////////////////////////////////////////////////////////////////////

  // Converter words enter here; a full store is overwritten.
  assign fifo_in_valid  = (r_q.st == ACQ_CONV) & conv_valid;
  // The output register refills whenever it is empty or being taken.
  assign fifo_out_ready = ~r_q.data_valid | host_ready;

  acq_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .force_wr  (1'b1),
    .in_data   (conv_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  //////////////////////////////////////////////////////////////////////////////

  // Computes every register's next value from the current state.
  always_comb begin
    r_d = r_q;
    r_d.conv_start = 1'b0;

    // Pins pass three flops; a level changes once stages two and three agree.
    r_d.sync1 = pins;
    r_d.sync2 = r_q.sync1;
    r_d.sync3 = r_q.sync2;
    for (int i = 0; i < ACQ_NPIN; i++) begin
      if (r_q.sync2[i] == r_q.sync3[i]) begin
        r_d.lvl[i] = r_q.sync3[i];
      end
    end
    rise = r_d.lvl & ~r_q.lvl;

    // Each action picks digital or, where fitted, the analog comparator.
    start_rise = (HAS_ANALOG && cfg.start_analog) ? rise[ACQ_PIN_ANALOG]
                                                  : rise[ACQ_PIN_START];
    ref_rise   = (HAS_ANALOG && cfg.ref_analog) ? rise[ACQ_PIN_ANALOG]
                                                : rise[ACQ_PIN_REF];
    pause_lvl  = cfg.pause_trig_en &
                 ((HAS_ANALOG && cfg.pause_analog) ? r_d.lvl[ACQ_PIN_ANALOG]
                                                   : r_d.lvl[ACQ_PIN_PAUSE]);

    // Pacing edges come from the divider or the external pin; a pause
    // freezes both so no new tick is raised, though a tick already pending is still sampled and counted.
    pace_tick = 1'b0;
    if (r_q.status.busy && !pause_lvl) begin
      if (cfg.ext_pacing) begin
        pace_tick = rise[ACQ_PIN_PACE];
      end else if (r_q.div_cnt >= cfg.pacing_div) begin
        pace_tick  = 1'b1;
        r_d.div_cnt = '0;
      end else begin
        r_d.div_cnt = r_q.div_cnt + 1'b1;
      end
    end
    if (pace_tick && (r_q.st != ACQ_WAIT_TRIG)) begin
      r_d.tick_pend = 1'b1;
    end

    // Post-reference samples only count once the reference has been seen.
    counting    = ~cfg.ref_trig_en | r_q.status.ref_seen;
    last_sample = ~cfg.continuous & counting &
                  (r_q.samples + 1'b1 >= cfg.sample_count);

    case (r_q.st)
      ACQ_IDLE: begin
        r_d.tick_pend = 1'b0;
        if (arm && cfg.hw_timed) begin
          if (cfg.ref_trig_en && cfg.continuous) begin
            r_d.status.config_err = 1'b1;
          end else begin
            r_d.status.config_err = 1'b0;
            r_d.status.busy       = 1'b1;
            r_d.status.done       = 1'b0;
            r_d.status.ref_seen   = 1'b0;
            r_d.samples           = '0;
            r_d.chan              = ACQ_RST_CHAN;
            r_d.div_cnt           = '0;
            r_d.st = cfg.start_trig_en ? ACQ_WAIT_TRIG : ACQ_RUN;
          end
        end else if (sw_convert && !cfg.hw_timed && fifo_in_ready) begin
          // One command, one conversion, no trigger involved.
          r_d.chan_sel = r_q.chan;
          r_d.range    = range_tab[r_q.chan];
          r_d.st       = ACQ_SETTLE;
        end
      end
      ACQ_WAIT_TRIG: begin
        r_d.div_cnt = '0;
        if (start_rise) begin
          r_d.st = ACQ_RUN;
        end
      end
      ACQ_RUN: begin
        if (r_q.tick_pend) begin
          r_d.tick_pend = pace_tick;
          r_d.chan_sel  = r_q.chan;
          r_d.range     = range_tab[r_q.chan];
          r_d.st        = ACQ_SETTLE;
        end
      end
      ACQ_SETTLE: begin
        // Range is on the amplifier one cycle before the start pulse.
        r_d.conv_start = 1'b1;
        r_d.st         = ACQ_CONV;
      end
      ACQ_CONV: begin
        if (conv_valid) begin
          r_d.chan = (r_q.chan >= cfg.scan_last) ? ACQ_RST_CHAN
                                                 : r_q.chan + 1'b1;
          if (!r_q.status.busy) begin
            r_d.st = ACQ_IDLE;
          end else if (last_sample) begin
            r_d.status.busy = 1'b0;
            r_d.status.done = 1'b1;
            r_d.st          = ACQ_IDLE;
          end else begin
            if (counting && !cfg.continuous) begin
              r_d.samples = r_q.samples + 1'b1;
            end
            r_d.st = ACQ_RUN;
          end
        end
      end
      default: begin
        r_d.st = ACQ_IDLE;
      end
    endcase

    // Reference point is marked once per run, paced runs only.
    if (r_q.status.busy && cfg.ref_trig_en && (r_q.st != ACQ_WAIT_TRIG) &&
        ref_rise) begin
      r_d.status.ref_seen = 1'b1;
    end

    // A host stop ends any paced run; a conversion in flight is dropped.
    if (stop && r_q.status.busy) begin
      r_d.status.busy = 1'b0;
      r_d.tick_pend   = 1'b0;
      r_d.conv_start  = 1'b0;
      r_d.st          = ACQ_IDLE;
    end

    // Overflow is sticky; a new overflow beats a clear in the same cycle.
    if (clr_overflow) begin
      r_d.status.overflow = 1'b0;
    end
    // A word leaving in the same cycle makes room, so nothing is lost then.
    if (fifo_in_valid && !fifo_in_ready &&
        !(fifo_out_valid && fifo_out_ready)) begin
      r_d.status.overflow = 1'b1;
    end

    // Output register toward the host.
    if (fifo_out_ready) begin
      r_d.data_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        r_d.data = fifo_out_data;
      end
    end

    // Transfer request: block-wise for DMA, per word for interrupts.
    if (!cfg.buffered) begin
      r_d.status.xfer_req = 1'b0;
    end else if (cfg.dma_mode) begin
      r_d.status.xfer_req = (fifo_level >= LW'(ACQ_DMA_THRESH)) |
                            ((fifo_level != '0) & ~r_d.status.busy);
    end else begin
      r_d.status.xfer_req = (fifo_level != '0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register and outputs.
  //////////////////////////////////////////////////////////////////////////////

  // Registers all state at once.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      r_q       <= '0;
      r_q.st    <= ACQ_IDLE;
      r_q.range <= ACQ_RST_RANGE;
      r_q.chan  <= ACQ_RST_CHAN;
    end else begin
      r_q <= r_d;
    end
  end

  // Every output is a field of the state register.
  assign conv_start_q = r_q.conv_start;
  assign chan_sel_q   = r_q.chan_sel;
  assign pga_range_q  = r_q.range;
  assign data_q       = r_q.data;
  assign data_valid_q = r_q.data_valid;
  assign status_q     = r_q.status;

endmodule : acq_sequencer

/* design/acq_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package acq_pkg;

  // Widths and sizes.
  localparam int ACQ_DATA_W     = 16;
  localparam int ACQ_FIFO_DEPTH = 16;
  localparam int ACQ_MAX_CH     = 16;
  localparam int ACQ_CH_W       = 4;
  localparam int ACQ_CNT_W      = 24;
  localparam int ACQ_DIV_W      = 16;
  localparam int ACQ_RANGE_W    = 2;
  localparam int ACQ_NPIN       = 5;
  localparam int ACQ_DMA_THRESH = 8;

  // Positions of the synchronised pins.
  localparam int ACQ_PIN_PACE   = 0;
  localparam int ACQ_PIN_START  = 1;
  localparam int ACQ_PIN_REF    = 2;
  localparam int ACQ_PIN_PAUSE  = 3;
  localparam int ACQ_PIN_ANALOG = 4;

  // Values after reset.
  localparam logic [ACQ_RANGE_W-1:0] ACQ_RST_RANGE = 2'h0;
  localparam logic [ACQ_CH_W-1:0]    ACQ_RST_CHAN  = 4'h0;

  typedef logic [ACQ_RANGE_W-1:0] acq_range_type;

  typedef enum logic [2:0] {
    ACQ_IDLE,
    ACQ_WAIT_TRIG,
    ACQ_RUN,
    ACQ_SETTLE,
    ACQ_CONV
  } acq_state_type;

  // Static configuration held by the host while an acquisition runs.
  typedef struct packed {
    logic                 hw_timed;
    logic                 continuous;
    logic                 ext_pacing;
    logic                 buffered;
    logic                 dma_mode;
    logic                 start_trig_en;
    logic                 ref_trig_en;
    logic                 pause_trig_en;
    logic                 start_analog;
    logic                 ref_analog;
    logic                 pause_analog;
    logic [ACQ_CNT_W-1:0] sample_count;
    logic [ACQ_DIV_W-1:0] pacing_div;
    logic [ACQ_CH_W-1:0]  scan_last;
  } acq_cfg_type;

  // Status flags shown to the host.
  typedef struct packed {
    logic busy;
    logic done;
    logic overflow;
    logic config_err;
    logic ref_seen;
    logic xfer_req;
  } acq_status_type;

endpackage : acq_pkg

/* design/acq_fifo.sv */
`timescale 1ns/1ps
module acq_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                       mclk,      // System clock.
  input  wire logic                       rstn,      // Sync reset, low.
  input  wire logic                       in_valid,  // Word offered.
  output logic                            in_ready,  // Room for a word.
  input  wire logic                       force_wr,  // Overwrite if full.
  input  wire logic [W-1:0]               in_data,   // Word to store.
  output logic                            out_valid, // Word available.
  input  wire logic                       out_ready, // Drain side takes.
  output logic [W-1:0]                    out_data,  // Oldest word.
  output logic [$clog2(DEPTH+1)-1:0]      level      // Words held.
);
  import acq_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } acq_fifo_st_type;

  acq_fifo_st_type r_q;
  acq_fifo_st_type r_d;
  logic            push;
  logic            pop;
  logic            drop;

  // Pointer arithmetic wraps, so the depth must be a power of two.
  if ((DEPTH < 2) || (DEPTH != (1 << AW)) || (W < 1)) begin : g_bad
    $error("acq_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready  = (r_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r_q.cnt != '0);
  assign out_data  = r_q.mem[r_q.rd];
  assign level     = r_q.cnt;

  // A forced write into a full store discards the oldest word.
  always_comb begin
    push = in_valid & (in_ready | force_wr);
    pop  = out_valid & out_ready;
    drop = push & ~in_ready & ~pop;
    r_d  = r_q;
    if (push) begin
      r_d.mem[r_q.wr] = in_data;
      r_d.wr          = r_q.wr + 1'b1;
    end
    if (pop | drop) begin
      r_d.rd = r_q.rd + 1'b1;
    end
    if (push & ~pop & ~drop) begin
      r_d.cnt = r_q.cnt + 1'b1;
    end else if (pop & ~push) begin
      r_d.cnt = r_q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : acq_fifo

/* bench/acq_chk.sv */
`timescale 1ns/1ps
module acq_chk import acq_pkg::*; #(
  parameter int DATA_W = ACQ_DATA_W,
  parameter int NCH    = ACQ_MAX_CH
) (
  input wire logic                   mclk,           // Clock.
  input wire logic                   rstn,           // Reset, low.
  input wire acq_pkg::acq_cfg_type   cfg,            // Setup.
  input wire acq_pkg::acq_range_type range_tab [NCH],// Ranges.
  input wire logic                   arm,            // Arm.
  input wire logic                   stop,           // Stop.
  input wire logic                   sw_convert,     // Command.
  input wire logic                   clr_overflow,   // Clear.
  input wire logic                   pacing_pin,     // Pacing.
  input wire logic                   start_pin,      // Start.
  input wire logic                   ref_pin,        // Reference.
  input wire logic                   pause_pin,      // Pause.
  input wire logic                   analog_cmp_pin, // Comparator.
  input wire logic                   conv_start_q,   // Conversion.
  input wire logic                   conv_valid,     // Result.
  input wire logic [DATA_W-1:0]      conv_data,      // Word.
  input wire logic [ACQ_CH_W-1:0]    chan_sel_q,     // Channel.
  input wire acq_pkg::acq_range_type pga_range_q,    // Range.
  input wire logic [DATA_W-1:0]      data_q,         // Sample.
  input wire logic                   data_valid_q,   // Present.
  input wire logic                   host_ready,     // Taken.
  input wire acq_pkg::acq_status_type status_q       // Flags.
);
  logic [4:0] pz_q;
  logic       pz_pin;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Counts how long the selected pause source has been held active.
  assign pz_pin = cfg.pause_analog ? analog_cmp_pin : pause_pin;
  always_ff @(posedge mclk) begin
    if (!rstn || !(cfg.pause_trig_en && pz_pin)) pz_q <= 5'h00;
    else if (pz_q != 5'h1F) pz_q <= pz_q + 5'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  pulse_once_a: assert property (conv_start_q |=> !conv_start_q)
    else $error("converter start longer than one cycle");
  sw_start_a: assert property (sw_convert && !cfg.hw_timed
    && !status_q.busy && !status_q.overflow |-> ##2 conv_start_q)
    else $error("command did not start a conversion");
  sw_only_a: assert property (conv_start_q && !cfg.hw_timed
    |-> $past(sw_convert, 2)) else $error("unrequested conversion");
  range_match_a: assert property (conv_start_q |->
    pga_range_q == range_tab[chan_sel_q] && $stable(chan_sel_q))
    else $error("amplifier range differs from channel range");
  arm_busy_a: assert property ($rose(status_q.busy)
    |-> $past(arm) && cfg.hw_timed) else $error("busy without arm");
  finite_end_a: assert property ($rose(status_q.done)
    |-> !status_q.busy && !cfg.continuous) else $error("bad run end");
  cont_run_a: assert property (status_q.busy && cfg.continuous
    && !stop |=> status_q.busy) else $error("continuous run ended");
  ref_cont_a: assert property (arm && cfg.hw_timed && cfg.ref_trig_en
    && cfg.continuous && !status_q.busy
    |=> status_q.config_err && !status_q.busy) else $error("bad setup ran");
  ovf_hold_a: assert property (status_q.overflow && !clr_overflow
    |=> status_q.overflow) else $error("overflow flag dropped");
  ovf_clr_a: assert property (clr_overflow && !conv_valid
    |=> !status_q.overflow) else $error("overflow flag not cleared");
  pause_hold_a: assert property (pz_q >= 5'h14 && cfg.hw_timed
    |-> !conv_start_q) else $error("conversion while paused");
  out_hold_a: assert property (data_valid_q && !host_ready
    |=> data_valid_q && $stable(data_q)) else $error("sample lost");

  cover property ($rose(status_q.overflow));
  cover property ($rose(status_q.done));
  cover property ($rose(status_q.config_err));
  cover property (conv_start_q && cfg.hw_timed);
endmodule : acq_chk

bind acq_sequencer acq_chk #(.DATA_W(DATA_W), .NCH(NCH)) acq_chk_inst (
  .mclk(mclk), .rstn(rstn), .cfg(cfg), .range_tab(range_tab), .arm(arm),
  .stop(stop), .sw_convert(sw_convert), .clr_overflow(clr_overflow),
  .pacing_pin(pacing_pin), .start_pin(start_pin), .ref_pin(ref_pin),
  .pause_pin(pause_pin), .analog_cmp_pin(analog_cmp_pin),
  .conv_start_q(conv_start_q), .conv_valid(conv_valid),
  .conv_data(conv_data), .chan_sel_q(chan_sel_q),
  .pga_range_q(pga_range_q), .data_q(data_q), .data_valid_q(data_valid_q),
  .host_ready(host_ready), .status_q(status_q)
);

/* bench/acq_conv_model.sv */
`timescale 1ns/1ps
module acq_conv_model import acq_pkg::*; (
  input  wire logic                mclk,         // Clock.
  input  wire logic                rstn,         // Reset, low.
  input  wire logic                conv_start_q, // Start pulse.
  input  wire logic [ACQ_CH_W-1:0] chan_sel_q,   // Channel.
  input  wire logic                slow,         // Long conversion.
  output logic                     conv_valid,   // Result pulse.
  output logic [ACQ_DATA_W-1:0]    conv_data     // Result word.
);
  logic [3:0]          left_q;
  logic [11:0]         seq_q;
  logic [ACQ_CH_W-1:0] ch_q;

  // One result per start; the word carries the channel and a running count,
  // and between results the lines flip so a stale read cannot pass.
  always_ff @(posedge mclk) begin
    conv_valid <= 1'b0;
    conv_data  <= ~conv_data;
    if (!rstn) begin
      left_q    <= 4'h0;
      seq_q     <= 12'h000;
      conv_data <= 16'h5A5A;
    end else if (conv_start_q) begin
      left_q <= slow ? 4'h6 : 4'h3;
      ch_q   <= chan_sel_q;
    end else if (left_q == 4'h1) begin
      left_q     <= 4'h0;
      conv_valid <= 1'b1;
      conv_data  <= {ch_q, seq_q};
      seq_q      <= seq_q + 12'h001;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
endmodule : acq_conv_model

/* bench/adc_acquisition_sequencer_tb_top.sv */
`timescale 1ns/1ps
module adc_acquisition_sequencer_tb_top;
  import acq_pkg::*;
  logic mclk, rstn, arm, stop, sw_convert, clr_overflow, host_ready, slow;
  logic pacing_pin, start_pin, ref_pin, pause_pin, analog_cmp_pin;
  logic conv_start_q, conv_valid, data_valid_q, hr_rand, pace_en;
  logic [ACQ_DATA_W-1:0] conv_data, data_q;
  logic [ACQ_CH_W-1:0]   chan_sel_q;
  logic [3:0]            cmd, pc;
  logic [31:0]           rnd;
  logic [15:0]           exp_q [$];
  acq_range_type         pga_range_q;
  acq_range_type         range_tab [ACQ_MAX_CH];
  acq_cfg_type           cfg;
  acq_status_type        status_q;
  int failures, total_checks, nconv, base, n;

  assign {arm, stop, sw_convert, clr_overflow} = cmd;
  always #12.5 mclk = ~mclk;

  acq_sequencer acq_sequencer_inst (
    .mclk(mclk), .rstn(rstn), .cfg(cfg), .range_tab(range_tab), .arm(arm),
    .stop(stop), .sw_convert(sw_convert), .clr_overflow(clr_overflow),
    .pacing_pin(pacing_pin), .start_pin(start_pin), .ref_pin(ref_pin),
    .pause_pin(pause_pin), .analog_cmp_pin(analog_cmp_pin),
    .conv_start_q(conv_start_q), .conv_valid(conv_valid),
    .conv_data(conv_data), .chan_sel_q(chan_sel_q),
    .pga_range_q(pga_range_q), .data_q(data_q),
    .data_valid_q(data_valid_q), .host_ready(host_ready),
    .status_q(status_q));
  acq_conv_model acq_conv_model_inst (
    .mclk(mclk), .rstn(rstn), .conv_start_q(conv_start_q),
    .chan_sel_q(chan_sel_q), .slow(slow), .conv_valid(conv_valid),
    .conv_data(conv_data));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk) #2;
  endtask : cyc

  task automatic pulse(input logic [3:0] m);
    cyc(1);
    cmd = m;
    cyc(1);
    cmd = 4'h0;
  endtask : pulse

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Notes the words of one run: channel wraps at the scan end.
  task automatic note(input int first, input int k, input int sl);
    for (int i = first; i < k; i++)
      exp_q.push_back({4'(i % (sl + 1)), 12'(base + i)});
  endtask : note

  task automatic wait_conv(input int k);
    for (int i = 0; i < 1000 && nconv < base + k; i++) cyc(1);
  endtask : wait_conv

  task automatic until_done;
    for (int i = 0; i < 2000 && status_q.done !== 1'b1; i++) cyc(1);
  endtask : until_done

  task automatic stop_after_conv;
    for (int i = 0; i < 200 && conv_valid !== 1'b1; i++) cyc(1);
    pulse(4'h4);
    cyc(2);
  endtask : stop_after_conv

  task automatic drain;
    hr_rand = 1'b1;
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) cyc(1);
    cyc(2);
    hr_rand = 1'b0;
    check(exp_q.size(), 0);
  endtask : drain

  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Random host stalls, random conversion time and gated external pacing.
  always @(posedge mclk) begin
    #2;
    rnd = lfsr(rnd);
    pc = pc + 4'h1;
    pacing_pin = pace_en & pc[3];
    host_ready = hr_rand & (rnd[0] | rnd[1]);
    slow = rnd[2];
  end

  // Counts results and compares each word taken with the oldest note.
  always @(posedge mclk) begin
    if (conv_valid === 1'b1) nconv++;
    if (rstn && data_valid_q === 1'b1 && host_ready === 1'b1)
      check(data_q, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
  end

  // Cuts a hang short.
  initial begin
    #500000;
    failures++;
    complete_run;
  end

  initial begin
    {mclk, rstn, cmd, cfg, slow, hr_rand, pace_en, pc} = '0;
    {start_pin, ref_pin, pause_pin, analog_cmp_pin, pacing_pin} = 5'h00;
    {host_ready, failures, total_checks, nconv} = '0;
    rnd = 32'hB334;
    for (int i = 0; i < ACQ_MAX_CH; i++) begin
      rnd = lfsr(rnd);
      range_tab[i] = rnd[1:0];
      // Ranges only step one way along the scan, so few large-to-small moves.
      if (i > 0 && range_tab[i] < range_tab[i-1])
        range_tab[i] = range_tab[i-1];
    end
    // Channel 2 sits between channels 1 and 3 and takes the range of 3.
    range_tab[2] = range_tab[3];
    cyc(2);
    rstn = 1'b1;
    cyc(1);
    check({status_q, data_valid_q, conv_start_q}, 8'h00);
    // On-demand commands while the pacing and start pins are active.
    {pace_en, start_pin, hr_rand} = 3'h7;
    for (int k = 0; k < 4; k++) begin
      base = nconv;
      note(0, 1, 0);
      pulse(4'h2);
      wait_conv(1);
      cyc(2);
    end
    cyc(40);
    check(nconv, base + 1);
    // Finite run from the internal divider over three channels.
    cfg.hw_timed = 1'b1;
    {cfg.buffered, cfg.dma_mode} = 2'h3;
    cfg.sample_count = 24'h000005;
    cfg.pacing_div = 16'h0009;
    cfg.scan_last = 4'h2;
    {base, hr_rand, start_pin} = {nconv, 2'h2};
    note(0, 5, 2);
    pulse(4'h8);
    until_done;
    check(nconv - base, 5);
    check(status_q.busy, 1'b0);
    drain;
    check(status_q.xfer_req, 1'b0);
    // External pacing held back by the start trigger, then a reference.
    {cfg.dma_mode, cfg.ext_pacing} = 2'h1;
    {cfg.start_trig_en, cfg.ref_trig_en} = 2'h3;
    cfg.sample_count = 24'h000003;
    cfg.scan_last = 4'h3;
    base = nconv;
    pulse(4'h8);
    cyc(80);
    check(nconv, base);
    start_pin = 1'b1;
    wait_conv(2);
    ref_pin = 1'b1;
    until_done;
    check({status_q.ref_seen, status_q.xfer_req}, 2'h3);
    note(0, nconv - base, 3);
    drain;
    {start_pin, ref_pin, pace_en} = 3'h0;
    // Continuous unbuffered run paused for a while by the comparator.
    cfg = '0;
    {cfg.hw_timed, cfg.continuous} = 2'h3;
    {cfg.pause_trig_en, cfg.pause_analog} = 2'h3;
    cfg.pacing_div = 16'h0013;
    cfg.scan_last = 4'h1;
    base = nconv;
    pulse(4'h8);
    cyc(60);
    analog_cmp_pin = 1'b1;
    cyc(16);
    n = nconv;
    cyc(60);
    check(nconv, n);
    analog_cmp_pin = 1'b0;
    cyc(60);
    check(status_q.busy, 1'b1);
    stop_after_conv;
    check(status_q.busy, 1'b0);
    note(0, nconv - base, 1);
    drain;
    // Host stalls until the buffer overflows; the oldest words are lost.
    cfg.pause_trig_en = 1'b0;
    cfg.pacing_div = 16'h000B;
    {cfg.buffered, cfg.dma_mode} = 2'h3;
    base = nconv;
    pulse(4'h8);
    wait_conv(20);
    stop_after_conv;
    n = nconv - base;
    check({status_q.overflow, status_q.xfer_req}, 2'h3);
    note(0, 1, 1);
    note(n - 16, n, 1);
    drain;
    check(status_q.overflow, 1'b1);
    pulse(4'h1);
    check(status_q.overflow, 1'b0);
    // A reference trigger with continuous mode is refused.
    cfg.ref_trig_en = 1'b1;
    pulse(4'h8);
    check({status_q.config_err, status_q.busy}, 2'h2);
    complete_run;
  end
endmodule : adc_acquisition_sequencer_tb_top
